// ===== rtl/cmd_decode_map.svh
`ifndef CMD_DECODE_MAP_SVH
`define CMD_DECODE_MAP_SVH
// first-edge opcode patterns on ca[4:0]
`define OPC_MPC 5'h00
`define OPC_PRE 5'h10
`define OPC_REF 5'h08
`define OPC_SRE 5'h18
`define OPC_WR1 5'h04
`define OPC_SRX 5'h14
`define OPC_MWR 5'h0C
`define OPC_RD1 5'h02
`define OPC_CAS 5'h12
`define OPC_MRW1 5'h06
`define OPC_MRW2 5'h16
`define OPC_MRR1 5'h0E
// clock restart recovery
`define TCK_PS 50000
`define TXP_PS 7500
`define TXP_NCK_MIN 5
`define TXP_CEIL ((`TXP_PS + `TCK_PS - 1) / `TCK_PS)
`define TXP_CYC (`TXP_CEIL > `TXP_NCK_MIN ? `TXP_CEIL : `TXP_NCK_MIN)
`define RESTART_CYC (2 + `TXP_CYC)
`define STOP_GUARD_CYC 4
`define BL_LONG 6'h20
`define BL_SHORT 6'h10
`endif

// ===== rtl/cmd_decode_pkg.sv
package cmd_decode_pkg;
   typedef enum logic [4:0]
   {
      CMD_NONE = 5'h00,
      CMD_MPC = 5'h01,
      CMD_PRE = 5'h02,
      CMD_REF = 5'h03,
      CMD_SRE = 5'h04,
      CMD_SRX = 5'h05,
      CMD_WR = 5'h06,
      CMD_MWR = 5'h07,
      CMD_RD = 5'h08,
      CMD_CAS = 5'h09,
      CMD_MRW1 = 5'h0A,
      CMD_MRW2 = 5'h0B,
      CMD_MRR = 5'h0C,
      CMD_ACT1 = 5'h0D,
      CMD_ACT2 = 5'h0E,
      CMD_ILLEGAL = 5'h0F
   } cmd_t;
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_SECOND = 2'b01,
      ST_LOCKED = 2'b10
   } dec_state_t;
endpackage : cmd_decode_pkg

// ===== rtl/cmd_decode.sv
`timescale 1ns/1ps
`include "cmd_decode_map.svh"
module cmd_decode
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic cke,
   input wire logic clk_restart,
   input wire logic bl_otf_en,
   input wire logic cs,
   input wire logic [5:0] ca,
   output cmd_decode_pkg::cmd_t cmd,
   output logic cmd_valid,
   output logic [2:0] bank,
   output logic all_bank,
   output logic auto_pre,
   output logic [5:0] burst_len,
   output logic [9:0] column,
   output logic [5:0] mr_addr,
   output logic [7:0] mr_op,
   output logic [6:0] mpc_op,
   output logic [13:0] row,
   output logic ready,
   output logic illegal
);
   import cmd_decode_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   dec_state_t state_q, state_d;
   cmd_t pend_q, pend_d;
   logic [5:0] ca1_q, ca1_d;
   logic [1:0] need_q, need_d;
   cmd_t cmd_q, cmd_d;
   logic valid_q, valid_d;
   logic [2:0] bank_q, bank_d;
   logic all_bank_q, all_bank_d;
   logic auto_pre_q, auto_pre_d;
   logic [5:0] bl_q, bl_d;
   logic [9:0] col_q, col_d;
   logic [5:0] ma_q, ma_d;
   logic [7:0] op_q, op_d;
   logic [6:0] mpc_q, mpc_d;
   logic [13:0] row_q, row_d;
   logic [3:0] rcnt_q, rcnt_d;
   logic ill_q, ill_d;
   cmd_t first_cmd;

   // first-edge classification
   always_comb
   begin
      first_cmd = CMD_ILLEGAL;
      if (ca[1:0] == 2'b01)
         first_cmd = CMD_ACT1;
      else if (ca[1:0] == 2'b11)
         first_cmd = CMD_ACT2;
      else if (ca[4:0] == `OPC_MPC)
         first_cmd = CMD_MPC;
      else if (ca[4:0] == `OPC_PRE)
         first_cmd = CMD_PRE;
      else if (ca[4:0] == `OPC_REF)
         first_cmd = CMD_REF;
      else if (ca[4:0] == `OPC_SRE)
         first_cmd = CMD_SRE;
      else if (ca[4:0] == `OPC_SRX)
         first_cmd = CMD_SRX;
      else if (ca[4:0] == `OPC_WR1)
         first_cmd = CMD_WR;
      else if (ca[4:0] == `OPC_MWR && !ca[5])
         first_cmd = CMD_MWR;
      else if (ca[4:0] == `OPC_RD1)
         first_cmd = CMD_RD;
      else if (ca[4:0] == `OPC_CAS)
         first_cmd = CMD_CAS;
      else if (ca[4:0] == `OPC_MRW1)
         first_cmd = CMD_MRW1;
      else if (ca[4:0] == `OPC_MRW2)
         first_cmd = CMD_MRW2;
      else if (ca[4:0] == `OPC_MRR1)
         first_cmd = CMD_MRR;
   end

   // ----------------------------------------
   // decoder next state
   // ----------------------------------------
   always_comb
   begin
      state_d = state_q;
      pend_d = pend_q;
      ca1_d = ca1_q;
      need_d = need_q;
      cmd_d = cmd_q;
      valid_d = 1'b0;
      bank_d = bank_q;
      all_bank_d = all_bank_q;
      auto_pre_d = auto_pre_q;
      bl_d = bl_q;
      col_d = col_q;
      ma_d = ma_q;
      op_d = op_q;
      mpc_d = mpc_q;
      row_d = row_q;
      ill_d = ill_q;
      // restart recovery counter
      rcnt_d = rcnt_q;
      if (clk_restart)
         rcnt_d = 4'(`RESTART_CYC);
      else if (rcnt_q != 4'h0)
         rcnt_d = rcnt_q - 4'h1;
      case (state_q)
         ST_IDLE:
         begin
            if (cs && rcnt_q == 4'h0)
            begin
               if (!cke)
                  ill_d = 1'b1;
               else if (first_cmd == CMD_ILLEGAL)
                  ill_d = 1'b1;
               else if (need_q == 2'b01 && first_cmd != CMD_CAS)
                  ill_d = 1'b1;
               else if (need_q == 2'b10 && first_cmd != CMD_MRW2)
                  ill_d = 1'b1;
               else if (need_q == 2'b00 && (first_cmd == CMD_CAS || first_cmd == CMD_MRW2))
                  ill_d = 1'b1;
               pend_d = first_cmd;
               ca1_d = ca;
               state_d = ST_SECOND;
            end
            else if (need_q != 2'b00)
               ill_d = 1'b1;
            if (ill_d)
               state_d = ST_LOCKED;
         end
         ST_SECOND:
         begin
            state_d = ST_IDLE;
            if (cs)
            begin
               ill_d = 1'b1;
               state_d = ST_LOCKED;
            end
            else
            begin
               cmd_d = pend_q;
               valid_d = 1'b1;
               need_d = 2'b00;
               case (pend_q)
                  CMD_MPC:
                  begin
                     mpc_d = {ca1_q[5], ca};
                     if (ca[5:4] != 2'b00 || ca[3:0] != 4'h0)
                        need_d = 2'b01;
                  end
                  CMD_PRE, CMD_REF:
                  begin
                     all_bank_d = ca1_q[5];
                     bank_d = ca[2:0];
                  end
                  CMD_WR, CMD_MWR, CMD_RD:
                  begin
                     bank_d = ca[2:0];
                     col_d[9] = ca[4];
                     auto_pre_d = ca[5];
                     bl_d = `BL_SHORT;
                     if (pend_q != CMD_MWR && bl_otf_en && ca1_q[5])
                        bl_d = `BL_LONG;
                     need_d = 2'b01;
                  end
                  CMD_CAS:
                  begin
                     col_d[8:0] = {ca1_q[5], ca, 2'b00};
                  end
                  CMD_MRW1:
                  begin
                     op_d[7] = ca1_q[5];
                     ma_d = ca;
                     need_d = 2'b10;
                  end
                  CMD_MRW2:
                  begin
                     op_d[6:0] = {ca1_q[5], ca};
                  end
                  CMD_MRR:
                  begin
                     ma_d = ca;
                     need_d = 2'b01;
                  end
                  CMD_ACT1:
                  begin
                     row_d[13:10] = {ca1_q[3:2], ca[5:4]};
                     bank_d = ca[2:0];
                  end
                  CMD_ACT2:
                  begin
                     row_d[9:0] = {ca1_q[5:2], ca};
                  end
                  default:
                     need_d = 2'b00; // SRE, SRX: second edge is a level only
               endcase
            end
         end
         ST_LOCKED:
         begin
            state_d = ST_LOCKED;
         end
         default:
         begin
            state_d = ST_LOCKED;
         end
      endcase
   end

   // register stage
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= ST_IDLE;
         pend_q <= CMD_NONE;
         ca1_q <= 6'h00;
         need_q <= 2'b00;
         cmd_q <= CMD_NONE;
         valid_q <= 1'b0;
         bank_q <= 3'h0;
         all_bank_q <= 1'b0;
         auto_pre_q <= 1'b0;
         bl_q <= `BL_SHORT;
         col_q <= 10'h000;
         ma_q <= 6'h00;
         op_q <= 8'h00;
         mpc_q <= 7'h00;
         row_q <= 14'h0000;
         rcnt_q <= 4'h0;
         ill_q <= 1'b0;
      end
      else if (clk_en)
      begin
         state_q <= state_d;
         pend_q <= pend_d;
         ca1_q <= ca1_d;
         need_q <= need_d;
         cmd_q <= cmd_d;
         valid_q <= valid_d;
         bank_q <= bank_d;
         all_bank_q <= all_bank_d;
         auto_pre_q <= auto_pre_d;
         bl_q <= bl_d;
         col_q <= col_d;
         ma_q <= ma_d;
         op_q <= op_d;
         mpc_q <= mpc_d;
         row_q <= row_d;
         rcnt_q <= rcnt_d;
         ill_q <= ill_d;
      end
   end

   // outputs
   assign cmd = cmd_q;
   assign cmd_valid = valid_q;
   assign bank = bank_q;
   assign all_bank = all_bank_q;
   assign auto_pre = auto_pre_q;
   assign burst_len = bl_q;
   assign column = col_q;
   assign mr_addr = ma_q;
   assign mr_op = op_q;
   assign mpc_op = mpc_q;
   assign row = row_q;
   assign ready = (rcnt_q == 4'h0) && (state_q != ST_LOCKED);
   assign illegal = ill_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence restart_s;
      clk_restart && clk_en;
   endsequence
   restart_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
      restart_s |=> !ready [*7])
      else $error("ready too early after restart");
   lock_stays_a: assert property (@(posedge sys_clk) disable iff (rst)
      illegal |=> illegal && !cmd_valid)
      else $error("illegal lock released");
   two_edge_a: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(cmd_valid) |-> $past(state_q) == ST_SECOND)
      else $error("command without second edge");
   ref_bank_a: assert property (@(posedge sys_clk) disable iff (rst)
      (clk_en && state_q == ST_SECOND && !cs && pend_q == CMD_REF)
      |=> all_bank == $past(ca1_q[5]) && bank == $past(ca[2:0]))
      else $error("refresh fields wrong");
   cas_col_a: assert property (@(posedge sys_clk) disable iff (rst)
      (clk_en && state_q == ST_SECOND && !cs && pend_q == CMD_CAS)
      |=> column[8:0] == {$past(ca1_q[5]), $past(ca), 2'b00})
      else $error("column bits wrong after cas-2");
   mwr_bl_a: assert property (@(posedge sys_clk) disable iff (rst)
      (cmd_valid && cmd == CMD_MWR) |-> burst_len == `BL_SHORT)
      else $error("mask write not burst 16");
   otf_bl_a: assert property (@(posedge sys_clk) disable iff (rst)
      (clk_en && state_q == ST_SECOND && !cs && pend_q == CMD_RD && bl_otf_en && ca1_q[5])
      |=> burst_len == `BL_LONG)
      else $error("burst 32 not selected");
   cke_low_a: assert property (@(posedge sys_clk) disable iff (rst)
      (clk_en && state_q == ST_IDLE && cs && !cke && ready) |=> illegal)
      else $error("command with cke low accepted");
   mrw_pair_a: assert property (@(posedge sys_clk) disable iff (rst)
      cmd_valid && cmd == CMD_MRW1 && clk_en && !(cs && cke && first_cmd == CMD_MRW2) |=> illegal)
      else $error("mrw-1 not followed by mrw-2");
endmodule : cmd_decode

// ===== bench/ctrl_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// controller stand-in on cs and ca
// ----------------------------------------
module ctrl_model
(
   input wire logic sys_clk,
   output logic cs,
   output logic cke,
   output logic [5:0] ca
);
   // bus parked deselected
   initial
   begin
      cs = 1'b0;
      cke = 1'b1;
      ca = 6'h00;
   end
   // two-edge command
   task automatic send(input logic [5:0] r1, input logic [5:0] r2, input logic ke);
      @(posedge sys_clk);
      cs <= 1'b1;
      cke <= ke;
      ca <= r1;
      @(posedge sys_clk);
      cs <= 1'b0;
      ca <= r2;
   endtask : send
   // faulty command: chip select still high on the second edge
   task automatic stuck(input logic [5:0] r1);
      @(posedge sys_clk);
      cs <= 1'b1;
      ca <= r1;
      @(posedge sys_clk);
      cs <= 1'b1;
      @(posedge sys_clk);
      cs <= 1'b0;
   endtask : stuck
   // deselect slots, bus toggles so stale values never look valid
   task automatic idle(input int n);
      repeat (n)
      begin
         @(posedge sys_clk);
         cs <= 1'b0;
         cke <= 1'b1;
         ca <= ~ca;
      end
   endtask : idle
endmodule : ctrl_model

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
   import cmd_decode_pkg::*;
   typedef struct {cmd_t c; logic [2:0] bank; logic ab; logic ap; logic [5:0] bl;
      logic [9:0] col; logic [5:0] ma; logic [7:0] op; logic [6:0] mop; logic [13:0] row;} ev_t;
   localparam int restart_cyc = 2 + 5; // two periods plus five-cycle exit delay
   logic sys_clk, rst = 1'b1, clk_en = 1'b1, clk_restart = 1'b0, bl_otf_en = 1'b1;
   logic cs, cke, cmd_valid, all_bank, auto_pre, ready, illegal;
   logic [5:0] ca, burst_len, mr_addr;
   logic [2:0] bank;
   logic [9:0] column;
   logic [7:0] mr_op;
   logic [6:0] mpc_op;
   logic [13:0] row;
   cmd_t cmd;
   ev_t seen[$];
   int err_count = 0;
   int checks_done = 0;
   // ----------------------------------------
   // parts
   // ----------------------------------------
   ctrl_model i_ctrl_model(.sys_clk(sys_clk), .cs(cs), .cke(cke), .ca(ca));
   cmd_decode i_cmd_decode(.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .cke(cke),
      .clk_restart(clk_restart), .bl_otf_en(bl_otf_en), .cs(cs), .ca(ca), .cmd(cmd),
      .cmd_valid(cmd_valid), .bank(bank), .all_bank(all_bank), .auto_pre(auto_pre),
      .burst_len(burst_len), .column(column), .mr_addr(mr_addr), .mr_op(mr_op),
      .mpc_op(mpc_op), .row(row), .ready(ready), .illegal(illegal));
   // clock
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // collect every decoded command
   always @(posedge sys_clk)
      if (cmd_valid === 1'b1)
         seen.push_back('{cmd, bank, all_bank, auto_pre, burst_len, column, mr_addr, mr_op,
            mpc_op, row});
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string m);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk_val
   task automatic chk_cmd(input cmd_t got, input cmd_t exp);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: cmd got %h exp %h", $time, got, exp);
      end
   endtask : chk_cmd
   task automatic do_reset;
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      seen.delete();
   endtask : do_reset
   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // every command back to back, pairs in consecutive slots
   task automatic sc_decode;
      logic [5:0] a [18] = '{6'h20, 6'h12, 6'h30, 6'h08, 6'h18, 6'h14, 6'h24, 6'h32, 6'h02,
         6'h12, 6'h0C, 6'h12, 6'h0E, 6'h12, 6'h26, 6'h16, 6'h05, 6'h2F};
      logic [5:0] b [18] = '{6'h15, 6'h00, 6'h05, 6'h03, 6'h00, 6'h00, 6'h36, 6'h2A, 6'h01,
         6'h00, 6'h02, 6'h00, 6'h2D, 6'h00, 6'h11, 6'h2B, 6'h14, 6'h15};
      cmd_t e [18] = '{CMD_MPC, CMD_CAS, CMD_PRE, CMD_REF, CMD_SRE, CMD_SRX, CMD_WR, CMD_CAS,
         CMD_RD, CMD_CAS, CMD_MWR, CMD_CAS, CMD_MRR, CMD_CAS, CMD_MRW1, CMD_MRW2, CMD_ACT1,
         CMD_ACT2};
      chk_cmd(cmd, CMD_NONE);
      chk_val(16'(burst_len), 16'h0010, "reset burst");
      chk_val(16'({ready, illegal}), 16'h0002, "reset flags");
      for (int i = 0; i < 18; i++)
         i_ctrl_model.send(a[i], b[i], 1'b1);
      i_ctrl_model.idle(4);
      chk_val(16'(seen.size()), 16'h0012, "count");
      for (int i = 0; i < 18 && i < seen.size(); i++)
         chk_cmd(seen[i].c, e[i]);
      if (seen.size() < 18)
         return;
      chk_val(16'(seen[0].mop), 16'h0055, "mpc op");
      chk_val(16'({seen[2].ab, seen[2].bank, seen[3].ab, seen[3].bank}), 16'h00D3, "pre ref");
      chk_val(16'({seen[6].bank, seen[6].ap, seen[6].bl}), 16'h0360, "wr");
      chk_val(16'(seen[7].col), 16'h03A8, "cas col");
      chk_val(16'({seen[8].bank, seen[8].ap, seen[8].bl}), 16'h0090, "rd");
      chk_val(16'(seen[10].bank), 16'h0002, "mwr bank");
      chk_val(16'(seen[12].ma), 16'h002D, "mrr addr");
      chk_val(16'({seen[15].ma, seen[15].op}), 16'h11AB, "mrw");
      chk_val(16'(seen[17].row), 16'h16D5, "row");
      chk_val(16'(seen[17].bank), 16'h0004, "act bank");
      chk_val(16'(illegal), 16'h0000, "legal run");
   endtask : sc_decode
   // faulty sequence locks the decoder until reset
   task automatic lock_case(input logic [5:0] a1, input logic [5:0] b1, input logic ke,
      input logic pair, input logic [5:0] a2);
      int n;
      do_reset();
      i_ctrl_model.send(a1, b1, ke);
      if (pair)
         i_ctrl_model.send(a2, 6'h00, 1'b1);
      i_ctrl_model.idle(3);
      chk_val(16'(illegal), 16'h0001, "lock");
      n = seen.size();
      i_ctrl_model.send(6'h30, 6'h00, 1'b1);
      i_ctrl_model.idle(3);
      chk_val(16'(seen.size()), 16'(n), "silent after lock");
   endtask : lock_case
   task automatic sc_lock;
      logic [5:0] rfu [4] = '{6'h1C, 6'h0A, 6'h1A, 6'h1E};
      foreach (rfu[i])
         lock_case(rfu[i], 6'h00, 1'b1, 1'b0, 6'h00);
      lock_case(6'h2C, 6'h00, 1'b1, 1'b1, 6'h12);
      lock_case(6'h30, 6'h00, 1'b0, 1'b0, 6'h00);
      lock_case(6'h24, 6'h00, 1'b1, 1'b0, 6'h00);
      lock_case(6'h12, 6'h00, 1'b1, 1'b0, 6'h00);
      lock_case(6'h26, 6'h11, 1'b1, 1'b1, 6'h30);
      do_reset();
      i_ctrl_model.stuck(6'h30);
      i_ctrl_model.idle(3);
      chk_val(16'(illegal), 16'h0001, "cs high on second edge");
   endtask : sc_lock
   // restart recovery, stretched by three frozen cycles
   task automatic sc_restart;
      int n;
      do_reset();
      i_ctrl_model.idle(4);
      @(posedge sys_clk);
      clk_restart <= 1'b1;
      @(posedge sys_clk);
      clk_restart <= 1'b0;
      clk_en <= 1'b0;
      n = 0;
      for (int i = 0; i < 16; i++)
      begin
         @(posedge sys_clk);
         if (ready === 1'b0)
            n++;
         clk_en <= (i >= 2);
      end
      chk_val(16'(n), 16'(restart_cyc + 3), "recovery");
      // a command inside a second recovery is ignored
      @(posedge sys_clk);
      clk_restart <= 1'b1;
      @(posedge sys_clk);
      clk_restart <= 1'b0;
      i_ctrl_model.send(6'h08, 6'h02, 1'b1);
      i_ctrl_model.idle(8);
      i_ctrl_model.send(6'h08, 6'h02, 1'b1);
      i_ctrl_model.idle(3);
      chk_val(16'(seen.size()), 16'h0001, "after recovery");
      // burst bit has no effect with on-the-fly off
      bl_otf_en <= 1'b0;
      i_ctrl_model.send(6'h24, 6'h00, 1'b1);
      i_ctrl_model.send(6'h12, 6'h00, 1'b1);
      i_ctrl_model.idle(3);
      chk_val(16'(seen.size()), 16'h0003, "otf off count");
      if (seen.size() > 1)
         chk_val(16'(seen[1].bl), 16'h0010, "otf off burst");
   endtask : sc_restart
   // ----------------------------------------
   // sequence and watchdog
   // ----------------------------------------
   initial
   begin
      do_reset();
      sc_decode();
      sc_lock();
      sc_restart();
      final_report();
   end
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      final_report();
   end
endmodule : tb
